// ---- core/pdf_frontend.sv ----
/*
 * Pressure DSP front end: sinc3 decimator, polynomial trim, PSI5
 * startup self-test sequencer and a small output buffer.
 * Assumes the modulator bit is asynchronous, all other inputs come
 * from logic on clk_sys, and coefficients are stable while running.
 */
`timescale 1ns/10ps
// Operation
// - In PSI5 mode both self-tests start by themselves at startup.
// - Each pass ends within iteration time; first starts after delay.
// - A failed pass is repeated up to the retry limit.
// - Running flag stays set until a pass succeeds or retries run out.
// - A passing test clears the fail flag; startup continues.
// - All passes failed: set fail flag, error state, send error word.
// - Fail flag once set clears only by device reset.
// - After self-test restart baseline filter phase and hold it in init.
// - Input is a one-bit modulator stream sampled at 1 MHz.
// - Third-order sinc decimates by 48, scaled by one over 48 cubed.
// - Trim path handles one 32-bit sample every 48 us.
// - Trim output is offset, x, x2, x3, dt, dt2 and x times dt terms.
// - Trim input is the sinc filter output directly.
// - Temperature difference is reading minus room reference.
// - Common-mode test compares cell signal to limit, fails if above.
module pdf_frontend
    import pdf_pkg::*;
#(
    parameter int START_CYC_P = ST_START_CYC,
    parameter int ITER_CYC_P = ST_ITER_CYC,
    parameter int BASE_CYC_P = BASE_INIT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic mod_bit,
    input wire logic psi5_mode,
    input wire logic [RPT_W-1:0] selftest_retry_limit,
    input wire logic [CM_W-1:0] cm_meas,
    input wire logic signed [TEMP_W-1:0] temp_code,
    input wire logic signed [TEMP_W-1:0] room_temp_reference,
    input wire pdf_coef_t coef,
    input wire logic out_ready,
    output logic out_valid,
    output pdf_word_t out_word,
    output logic selftest_running_flag,
    output logic selftest_fail_flag,
    output logic init_done,
    output logic baseline_restart,
    output logic baseline_init_hold
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic [DIV_W-1:0] div;
        logic [DCNT_W-1:0] dcnt;
        logic [ACC_W-1:0] i1;
        logic [ACC_W-1:0] i2;
        logic [ACC_W-1:0] i3;
        logic [ACC_W-1:0] c1;
        logic [ACC_W-1:0] c2;
        logic [ACC_W-1:0] c3;
        logic sinc_v;
        logic signed [SMP_W-1:0] sinc_x;
        logic trim_v;
        logic [TRIM_W-1:0] trim_d;
        pdf_phase_t st;
        logic psi5;
        logic [CNT_W-1:0] cnt;
        logic [RPT_W-1:0] tries;
        logic cm_bad;
        logic dig_seen;
        logic running;
        logic fail;
        logic done;
        logic base_rst;
        logic base_hold;
    } pdf_state_t;

    pdf_state_t st_reg;
    pdf_state_t st_next;
    logic fifo_in_valid;
    logic fifo_in_ready;
    pdf_word_t fifo_in;
    logic pass_end;
    logic pass_ok;
    logic consume;

    function automatic logic [TRIM_W-1:0] sat32(logic signed [63:0] v);
        logic signed [63:0] hi;
        logic signed [63:0] lo;
        hi = 64'sh0000_0000_7FFF_FFFF;
        lo = -64'sh0000_0000_8000_0000;
        if (v > hi) begin
            return hi[TRIM_W-1:0];
        end else if (v < lo) begin
            return lo[TRIM_W-1:0];
        end
        return v[TRIM_W-1:0];
    endfunction

    assign pass_end = st_reg.st == PDF_PASS
        && st_reg.cnt == CNT_W'(ITER_CYC_P - 1);
    assign pass_ok = !st_reg.cm_bad && !(cm_meas > CM_LIMIT)
        && (st_reg.dig_seen || st_reg.sinc_v);
    assign consume = st_reg.trim_v && (fifo_in_ready || !st_reg.done);
    assign fifo_in_valid = st_reg.trim_v && st_reg.done;
    assign fifo_in.err = st_reg.fail;
    assign fifo_in.data = st_reg.fail ? ST_ERR_MSG : st_reg.trim_d;

    always_comb begin
        logic [ACC_W-1:0] bit_in;
        logic [ACC_W-1:0] y1;
        logic [ACC_W-1:0] y2;
        logic [ACC_W-1:0] y3;
        logic signed [63:0] scaled;
        logic signed [63:0] x;
        logic signed [63:0] dt;
        logic signed [63:0] x2;
        logic signed [63:0] x3;
        logic signed [63:0] acc;
        bit_in = '0;
        y1 = '0;
        y2 = '0;
        y3 = '0;
        scaled = '0;
        x = '0;
        dt = '0;
        x2 = '0;
        x3 = '0;
        acc = '0;
        st_next = st_reg;
        st_next.sinc_v = 1'b0;
        st_next.base_rst = 1'b0;

        // Modulator bit synchroniser and 1 MHz sample tick
        st_next.s1 = mod_bit;
        st_next.s2 = st_reg.s1;
        st_next.div = (st_reg.div == DIV_W'(MOD_DIV - 1)) ? '0
            : st_reg.div + 1'b1;
        if (st_reg.div == '0) begin
            bit_in = st_reg.s2 ? ACC_W'(1) : '1;
            st_next.i1 = st_reg.i1 + bit_in;
            st_next.i2 = st_reg.i2 + st_next.i1;
            st_next.i3 = st_reg.i3 + st_next.i2;
            st_next.dcnt = (st_reg.dcnt == DCNT_W'(DECIM - 1)) ? '0
                : st_reg.dcnt + 1'b1;
            if (st_reg.dcnt == DCNT_W'(DECIM - 1)) begin
                // Comb section at the decimated rate
                y1 = st_next.i3 - st_reg.c1;
                y2 = y1 - st_reg.c2;
                y3 = y2 - st_reg.c3;
                st_next.c1 = st_next.i3;
                st_next.c2 = y1;
                st_next.c3 = y2;
                scaled = (64'(signed'(y3)) * 64'(SINC_RECIP)) >>> RECIP_SH;
                st_next.sinc_x = scaled[SMP_W-1:0];
                st_next.sinc_v = 1'b1;
            end
        end

        // Polynomial trim, one evaluation per sinc sample
        x = 64'(signed'(st_reg.sinc_x));
        dt = 64'(temp_code) - 64'(room_temp_reference);
        x2 = (x * x) >>> SMP_FRAC;
        x3 = (x2 * x) >>> SMP_FRAC;
        acc = (64'(coef.c_off) <<< SMP_FRAC)
            + 64'(coef.c_lin) * x
            + 64'(coef.c_sq) * x2
            + 64'(coef.c_cube) * x3
            + 64'(coef.c_t) * dt
            + 64'(coef.c_tt) * (dt * dt)
            + 64'(coef.c_xt) * ((x * dt) >>> COEF_FRAC);
        if (consume) begin
            st_next.trim_v = 1'b0;
        end
        if (st_reg.sinc_v && (!st_reg.trim_v || consume)) begin
            st_next.trim_v = 1'b1;
            st_next.trim_d = sat32(acc >>> COEF_FRAC);
        end

        // Startup self-test sequencer
        unique case (st_reg.st)
            PDF_BOOT: begin
                st_next.psi5 = psi5_mode;
                st_next.cnt = '0;
                if (psi5_mode) begin
                    st_next.st = PDF_DELAY;
                end else begin
                    st_next.st = PDF_RUN;
                    st_next.done = 1'b1;
                end
            end
            PDF_DELAY: begin
                st_next.cnt = st_reg.cnt + 1'b1;
                if (st_reg.cnt == CNT_W'(START_CYC_P - 1)) begin
                    st_next.st = PDF_PASS;
                    st_next.cnt = '0;
                    st_next.tries = '0;
                    st_next.running = 1'b1;
                    st_next.fail = 1'b0;
                    st_next.cm_bad = 1'b0;
                    st_next.dig_seen = 1'b0;
                end
            end
            PDF_PASS: begin
                st_next.cnt = st_reg.cnt + 1'b1;
                if (cm_meas > CM_LIMIT) begin
                    st_next.cm_bad = 1'b1;
                end
                if (st_reg.sinc_v) begin
                    st_next.dig_seen = 1'b1;
                end
                if (pass_end) begin
                    st_next.cnt = '0;
                    st_next.cm_bad = 1'b0;
                    st_next.dig_seen = 1'b0;
                    if (pass_ok) begin
                        st_next.running = 1'b0;
                        st_next.fail = 1'b0;
                        st_next.st = PDF_BASE;
                        st_next.base_rst = 1'b1;
                        st_next.base_hold = 1'b1;
                    end else if (st_reg.tries == selftest_retry_limit) begin
                        st_next.running = 1'b0;
                        st_next.fail = 1'b1;
                        st_next.st = PDF_BASE;
                        st_next.base_rst = 1'b1;
                        st_next.base_hold = 1'b1;
                    end else begin
                        st_next.tries = st_reg.tries + 1'b1;
                    end
                end
            end
            PDF_BASE: begin
                st_next.cnt = st_reg.cnt + 1'b1;
                if (st_reg.cnt == CNT_W'(BASE_CYC_P - 1)) begin
                    st_next.base_hold = 1'b0;
                    st_next.done = 1'b1;
                    st_next.st = st_reg.fail ? PDF_ERR : PDF_RUN;
                end
            end
            PDF_RUN: begin
                st_next.cnt = '0;
            end
            PDF_ERR: begin
                st_next.cnt = '0;
            end
            default: begin
                st_next.st = PDF_BOOT;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    pdf_fifo #(
        .WIDTH($bits(pdf_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_word)
    );

    assign selftest_running_flag = st_reg.running;
    assign selftest_fail_flag = st_reg.fail;
    assign init_done = st_reg.done;
    assign baseline_restart = st_reg.base_rst;
    assign baseline_init_hold = st_reg.base_hold;

    // Helper: cycles between sinc samples
    logic [12:0] gap_reg;
    logic gap_seen_reg;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'b0;
        end else if (st_reg.sinc_v) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    AST_AUTO_START: assert property (
        $rose(st_reg.running) |-> st_reg.psi5
            && $past(st_reg.st) == PDF_DELAY
            && $past(st_reg.cnt) == CNT_W'(START_CYC_P - 1))
        else $error("self-test started without delay or outside PSI5");
    AST_ITER_BOUND: assert property (
        st_reg.st == PDF_PASS |-> st_reg.cnt < CNT_W'(ITER_CYC_P))
        else $error("self-test pass overran its iteration time");
    AST_RETRY: assert property (
        pass_end && !pass_ok && st_reg.tries != selftest_retry_limit
        |=> st_reg.st == PDF_PASS && st_reg.running
            && st_reg.tries == $past(st_reg.tries) + 1'b1)
        else $error("failed pass was not retried");
    AST_RUN_CLEAR: assert property (
        $fell(st_reg.running) |-> $past(pass_ok)
            || $past(st_reg.tries) == $past(selftest_retry_limit))
        else $error("running flag cleared too early");
    AST_PASS_CLEAR: assert property (
        pass_end && pass_ok |=> !st_reg.fail && !st_reg.running)
        else $error("passing test left fail or running set");
    AST_ERR_WORD: assert property (
        out_valid && st_reg.fail |-> out_word.data == ST_ERR_MSG
            && out_word.err)
        else $error("sensor data sent after failed self-test");
    AST_FAIL_STICKY: assert property (
        st_reg.fail |=> st_reg.fail)
        else $error("fail flag cleared without reset");
    AST_BASE_RESTART: assert property (
        $fell(st_reg.running) |-> st_reg.base_rst && st_reg.base_hold
            ##1 !st_reg.base_rst && st_reg.base_hold)
        else $error("baseline filter not restarted after self-test");
    AST_SINC_RATE: assert property (
        st_reg.sinc_v && gap_seen_reg |-> gap_reg == 13'h12BF)
        else $error("sinc output not every 48 modulator samples");
    AST_TRIM_EACH: assert property (
        st_reg.sinc_v && !st_reg.trim_v |=> st_reg.trim_v)
        else $error("trim not evaluated for a sinc sample");

    COV_PASS_FIRST: cover property (pass_end && pass_ok
        && st_reg.tries == '0);
    COV_RETRY: cover property (pass_end && !pass_ok
        && st_reg.tries != selftest_retry_limit);
    COV_ERR_END: cover property (st_reg.st == PDF_ERR && out_valid);
    COV_RUN_DATA: cover property (st_reg.st == PDF_RUN && out_valid
        && out_ready);
endmodule // pdf_frontend

// ---- core/pdf_pkg.sv ----
/*
 * Shared constants and types of the pressure DSP front end.
 * Assumes a 100 MHz system clock and a 1 MHz modulator bit rate.
 */
package pdf_pkg;

    // Clock and modulator rates
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int MOD_RATE_HZ = 1_000_000;
    localparam int MOD_DIV = CLK_HZ / MOD_RATE_HZ;

    // Sinc filter
    localparam int DECIM = 48;
    localparam int SINC_ORDER = 3;
    localparam int ACC_W = 24;
    localparam int SMP_W = 23;
    localparam int SMP_FRAC = 22;
    localparam logic [31:0] SINC_RECIP = 32'h0000_97B4;
    localparam int RECIP_SH = 10;
    localparam int DIV_W = 7;
    localparam int DCNT_W = 6;

    // Trim stage
    localparam int TRIM_W = 32;
    localparam int COEF_W = 16;
    localparam int COEF_FRAC = 12;
    localparam int TEMP_W = 16;

    // Self-test timing, in microseconds and in cycles
    localparam int ST_START_US = 1000;
    localparam int ST_ITER_US = 500;
    localparam int BASE_INIT_US = 2000;
    localparam int ST_START_CYC = ST_START_US * CYC_PER_US;
    localparam int ST_ITER_CYC = ST_ITER_US * CYC_PER_US;
    localparam int BASE_INIT_CYC = BASE_INIT_US * CYC_PER_US;
    localparam int CNT_W = 24;

    // Self-test limits and the error word
    localparam int RPT_W = 4;
    localparam int CM_W = 12;
    localparam logic [CM_W-1:0] CM_LIMIT = 12'hC00;
    localparam logic [TRIM_W-1:0] ST_ERR_MSG = 32'hDEAD_0001;

    // Output buffer
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        PDF_BOOT,
        PDF_DELAY,
        PDF_PASS,
        PDF_BASE,
        PDF_RUN,
        PDF_ERR
    } pdf_phase_t;

    typedef struct packed {
        logic signed [COEF_W-1:0] c_off;
        logic signed [COEF_W-1:0] c_lin;
        logic signed [COEF_W-1:0] c_sq;
        logic signed [COEF_W-1:0] c_cube;
        logic signed [COEF_W-1:0] c_t;
        logic signed [COEF_W-1:0] c_tt;
        logic signed [COEF_W-1:0] c_xt;
    } pdf_coef_t;

    typedef struct packed {
        logic err;
        logic [TRIM_W-1:0] data;
    } pdf_word_t;

endpackage

// ---- core/pdf_fifo.sv ----
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
module pdf_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } pdf_fifo_st_t;

    pdf_fifo_st_t st_reg;
    pdf_fifo_st_t st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_reg.cnt != '0;
    assign out_data = mem[st_reg.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[st_reg.wp] <= in_data;
        end
    end
endmodule // pdf_fifo

// ---- sim/pdf_mod_model.sv ----
/*
 * Behavioural modulator in front of the pressure DSP front end.
 * Assumes the 100 MHz system clock; gives one bit per 1 MHz tick.
 */
`timescale 1ns/10ps
module pdf_mod_model
    import pdf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic level,
    output logic mod_bit
);
    int tick_cnt;

    // Full-scale stream, new bit once per modulator period
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tick_cnt <= 0;
            mod_bit <= 1'b0;
        end else if (tick_cnt == MOD_DIV - 1) begin
            tick_cnt <= 0;
            mod_bit <= level;
        end else begin
            tick_cnt <= tick_cnt + 1;
        end
    end
endmodule // pdf_mod_model

// ---- sim/pdf_frontend_tb_top.sv ----
/*
 * Self-checking bench of the pressure DSP front end.
 * Assumes shortened self-test counts and the modulator model.
 */
`timescale 1ns/10ps
module pdf_frontend_tb_top
    import pdf_pkg::*;
;
    localparam int START_P = 200;
    localparam int ITER_P = 6000;
    localparam int BASE_P = 50;
    localparam int X1 = 4194288;

    typedef struct {
        logic [RPT_W-1:0] retry;
        int bad;
        logic lvl;
        int dt;
    } pdf_row_t;

    pdf_row_t rows [4] = '{'{4'h0, 0, 1'b1, 5}, '{4'h0, 1, 1'b0, -3},
        '{4'h1, 1, 1'b0, 7}, '{4'h1, 2, 1'b1, 0}};

    logic clk_sys = 1'b0;
    logic resetn, mod_bit, psi5_mode, lvl, out_ready, out_valid;
    logic selftest_running_flag, selftest_fail_flag, init_done;
    logic baseline_restart, baseline_init_hold;
    logic [RPT_W-1:0] retry;
    logic [CM_W-1:0] cm_meas;
    logic signed [TEMP_W-1:0] temp_code, room_ref;
    pdf_coef_t coef;
    pdf_word_t out_word;
    int err_count = 0;
    int comparisons = 0;
    int cyc, start_at, run_cnt, hold_cnt, rst_cnt, early;

    always #5 clk_sys = ~clk_sys;

    pdf_mod_model u_mod (.clk_sys(clk_sys), .resetn(resetn), .level(lvl),
        .mod_bit(mod_bit));

    pdf_frontend #(.START_CYC_P(START_P), .ITER_CYC_P(ITER_P),
        .BASE_CYC_P(BASE_P)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .mod_bit(mod_bit),
        .psi5_mode(psi5_mode), .selftest_retry_limit(retry),
        .cm_meas(cm_meas), .temp_code(temp_code),
        .room_temp_reference(room_ref), .coef(coef),
        .out_ready(out_ready), .out_valid(out_valid), .out_word(out_word),
        .selftest_running_flag(selftest_running_flag),
        .selftest_fail_flag(selftest_fail_flag), .init_done(init_done),
        .baseline_restart(baseline_restart),
        .baseline_init_hold(baseline_init_hold));

    // Event counters since the last reset release
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cyc = 0;
            start_at = -1;
            run_cnt = 0;
            hold_cnt = 0;
            rst_cnt = 0;
            early = 0;
        end else begin
            cyc++;
            if (selftest_running_flag === 1'b1) begin
                run_cnt++;
                if (start_at < 0) start_at = cyc;
            end
            if (baseline_init_hold === 1'b1) hold_cnt++;
            if (baseline_restart === 1'b1) rst_cnt++;
            if (out_valid === 1'b1 && init_done !== 1'b1) early++;
        end
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic ok(input logic cond);
        chk({32'h0, cond}, 33'h1);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        resetn <= 1'b0;
        @(negedge clk_sys);
        chk({out_valid, selftest_running_flag, selftest_fail_flag,
            init_done, baseline_restart, baseline_init_hold}, 33'h0);
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask

    task automatic wait_run();
        int n;
        for (n = 0; n < 1000 && selftest_running_flag !== 1'b1; n++)
            @(negedge clk_sys);
        @(negedge clk_sys);
        ok(start_at >= START_P && start_at <= START_P + 3);
    endtask

    task automatic run_row(input pdf_row_t r);
        int n;
        int passes;
        logic fl;
        logic [31:0] e;
        fl = (r.bad > r.retry);
        passes = fl ? r.retry + 1 : r.bad + 1;
        e = 32'(1024 + (r.lvl ? X1 : -X1) + r.dt);
        @(posedge clk_sys);
        psi5_mode <= 1'b1;
        retry <= r.retry;
        lvl <= r.lvl;
        temp_code <= 16'(256 + r.dt);
        cm_meas <= (r.bad > 0) ? 12'hC01 : 12'hC00;
        do_reset();
        wait_run();
        if (r.bad > 0) begin
            repeat (r.bad * ITER_P - 100) @(posedge clk_sys);
            cm_meas <= 12'hC00;
        end
        for (n = 0; n < 20000 && init_done !== 1'b1; n++)
            @(negedge clk_sys);
        chk(selftest_fail_flag, fl);
        chk(selftest_running_flag, 1'b0);
        ok(run_cnt >= passes * ITER_P - 2);
        ok(run_cnt <= passes * ITER_P + 2);
        chk(rst_cnt, 33'h1);
        chk(hold_cnt, 33'(BASE_P));
        if (!fl) begin
            // Drop words from the settling sinc window
            @(posedge clk_sys);
            out_ready <= 1'b1;
            do begin
                @(posedge clk_sys);
            end while (cyc < 5 * DECIM * MOD_DIV / 2);
            out_ready <= 1'b0;
        end
        for (n = 0; n < 6000 && out_valid !== 1'b1; n++)
            @(negedge clk_sys);
        chk(out_word, {fl, fl ? ST_ERR_MSG : e});
        chk(early, 33'h0);
        @(posedge clk_sys);
        out_ready <= 1'b1;
        @(posedge clk_sys);
        out_ready <= 1'b0;
        chk(selftest_fail_flag, fl);
    endtask

    initial begin
        int n;
        int i;
        resetn = 1'b0;
        psi5_mode = 1'b0;
        lvl = 1'b1;
        out_ready = 1'b0;
        retry = 4'h0;
        cm_meas = 12'h000;
        room_ref = 16'sh0100;
        temp_code = 16'sh0100;
        coef = '{16'sh0001, 16'sh1000, 16'sh0000, 16'sh0000, 16'sh1000,
            16'sh0000, 16'sh0000};
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        for (i = 0; i < 4; i++) run_row(rows[i]);
        // Fail flag survives time, clears only by reset
        repeat (1000) @(posedge clk_sys);
        chk(selftest_fail_flag, 1'b1);
        psi5_mode <= 1'b0;
        lvl <= 1'b1;
        temp_code <= 16'sh0105;
        do_reset();
        repeat (4) @(negedge clk_sys);
        chk({init_done, selftest_running_flag, selftest_fail_flag},
            33'h4);
        // Fill the buffer while stalled, then drain back to back
        repeat (6 * DECIM * MOD_DIV) @(posedge clk_sys);
        chk(out_valid, 1'b1);
        out_ready <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(negedge clk_sys);
            if (out_valid !== 1'b1) break;
        end
        ok(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1);
        for (n = 0; n < 6000 && out_valid !== 1'b1; n++)
            @(negedge clk_sys);
        chk(out_word, {1'b0, 32'(1024 + X1 + 5)});
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (out_valid !== 1'b1 && n < 6000);
        chk(n, 33'(DECIM * MOD_DIV));
        chk(rst_cnt, 33'h0);
        @(posedge clk_sys);
        out_ready <= 1'b0;
        psi5_mode <= 1'b1;
        do_reset();
        wait_run();
        repeat (1000) @(posedge clk_sys);
        do_reset();
        wait_run();
        wrap_up();
    end

    initial begin
        #1_000_000;
        err_count++;
        wrap_up();
    end
endmodule // pdf_frontend_tb_top
